// ---- rtl/ics_defs.svh ----
// Register offsets, field positions and timing constants of the status collector
`ifndef ICS_DEFS_SVH
`define ICS_DEFS_SVH

// Register byte offsets
`define ICS_OFF_IRQ_CFG 8'h54
`define ICS_OFF_STATUS 8'h58
`define ICS_OFF_ENABLE 8'h5c
`define ICS_OFF_POWER 8'h60
`define ICS_OFF_BYTE_TEST 8'h64

// Fixed values and masks
`define ICS_BYTE_TEST_VAL 32'h8765_4321
`define ICS_STS_IMPL_MASK 32'h83bf_efff
`define ICS_STS_CLR_MASK 32'h83bb_efff
`define ICS_STS_RESET 32'h0000_0000
`define ICS_ENA_RESET 32'h0000_0000
`define ICS_DROP_MIDPOINT 32'h8000_0000
`define ICS_TIMER_ALL_ONES 16'hffff
`define ICS_TIMER_ZERO 16'h0000

// Status bit positions
`define ICS_BIT_SW 31
`define ICS_BIT_TX_HALT 25
`define ICS_BIT_RX_HALT 24
`define ICS_BIT_DROP_MID 23
`define ICS_BIT_TRANSMIT_BUFFER_COMPLETE_FLAG 21
`define ICS_BIT_RX_DMA 20
`define ICS_BIT_TIMER 19
`define ICS_BIT_PHY 18
`define ICS_BIT_POWER 17
`define ICS_BIT_TX_STS_OVF 16
`define ICS_BIT_RX_OVERSIZE 15
`define ICS_BIT_RX_ERR 14
`define ICS_BIT_TX_ERR 13
`define ICS_BIT_TX_UNDERRUN 11
`define ICS_BIT_TX_OVERRUN 10
`define ICS_BIT_TX_SPACE 9
`define ICS_BIT_TX_STS_FULL 8
`define ICS_BIT_TX_STS_LVL 7
`define ICS_BIT_RX_DROPPED 6
`define ICS_BIT_RX_DATA_LVL 5
`define ICS_BIT_RX_STS_FULL 4
`define ICS_BIT_RX_STS_LVL 3
`define ICS_BIT_PIN_LSB 0

// Hold-off configuration and power control fields
`define ICS_DEAS_MSB 31
`define ICS_DEAS_LSB 24
`define ICS_DEAS_CLR_BIT 14
`define ICS_DEAS_STS_BIT 13
`define ICS_IRQ_INT_BIT 12
`define ICS_PWR_SLEEP_BIT 0

// Timing: hold-off unit in ns, clock period in ns, unit length in cycles
`define ICS_CLK_PERIOD_NS 8
`define ICS_HOLDOFF_UNIT_NS 10000
`define ICS_HOLDOFF_UNIT_CYC (`ICS_HOLDOFF_UNIT_NS / `ICS_CLK_PERIOD_NS)
`define ICS_PRESCALE_W 11

// AHB transfer type
`define ICS_HTRANS_NONSEQ 2'b10

`endif

// ---- rtl/ics_pkg.sv ----
// Types shared by the interrupt status collector
`default_nettype none
package ics_pkg;
  // Bus slave phase: waiting for an address, or performing the access
  typedef enum logic {
    ICS_BUS_IDLE,
    ICS_BUS_ACCESS
  } ics_bus_state_t;
  typedef logic [31:0] ics_word_t;
endpackage
`default_nettype wire

// ---- rtl/ics_collector.sv ----
// Interrupt status collector with enable mask, hold-off and AHB-Lite registers
`include "ics_defs.svh"
`default_nettype none
module ics_collector #(
  parameter int ADDR_W = 8,
  parameter int PIN_W = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [ADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire ics_pkg::ics_word_t i_hwdata,
  output ics_pkg::ics_word_t o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Event sources
  input wire logic i_tx_halt_req,
  input wire logic i_tx_halted,
  input wire logic i_rx_halted,
  input wire ics_pkg::ics_word_t i_drop_count,
  input wire logic i_tx_buf_done_ioc,
  input wire logic i_rx_dma_done,
  input wire logic [15:0] i_timer_count,
  input wire logic i_phy_event,
  input wire logic i_power_event,
  input wire logic i_tx_status_overflow,
  input wire logic i_rx_oversize,
  input wire logic i_rx_error,
  input wire logic i_tx_error,
  input wire logic i_tx_data_write,
  input wire logic i_tx_data_full,
  input wire logic i_tx_data_underrun,
  input wire logic i_tx_space_above,
  input wire logic i_tx_status_full,
  input wire logic i_tx_status_level,
  input wire logic i_rx_frame_dropped,
  input wire logic i_rx_data_level,
  input wire logic i_rx_status_full,
  input wire logic i_rx_status_level,
  input wire logic [PIN_W-1:0] i_pin_events,
  // Results
  output logic o_irq,
  output logic o_low_power
);
  import ics_pkg::*;

  // Rising-edge helper, used for the software and drop-midpoint bits
  function automatic logic ics_rose(input logic prev, input logic cur);
    ics_rose = cur & ~prev;
  endfunction

  // Offset compare helper for the register decode; address bits above
  // the low byte are ignored, so the map repeats every 256 bytes
  function automatic logic ics_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    ics_hit = (addr[7:0] == off);
  endfunction

  // Bus slave state
  ics_bus_state_t bus_state_q;
  logic [ADDR_W-1:0] addr_q;
  logic write_q;
  logic hready_q;
  ics_word_t hrdata_q;
  // Status, enable and their next-state terms
  ics_word_t status_q;
  ics_word_t status_d;
  ics_word_t enable_q;
  ics_word_t set_vec;
  ics_word_t clr_vec;
  // Hold-off interval and interrupt output
  logic [7:0] deas_q;
  logic [7:0] holdoff_cnt_q;
  logic [`ICS_PRESCALE_W-1:0] prescale_q;
  logic unit_tick;
  logic irq_q;
  logic irq_d;
  // Power state and source history
  logic low_power_q;
  logic phy_q;
  logic drop_top_q;
  logic [15:0] timer_prev_q;
  // Decoded strobes and pending terms
  logic sw_en_set;
  logic access_go;
  logic wr_status;
  logic wr_enable;
  logic wr_cfg;
  logic wr_power;
  logic wr_byte_test;
  logic pend_power;
  logic pend_other;
  logic holdoff_active;
  logic holdoff_load;

  // Address phase taken only on a selected NONSEQ with the bus ready
  // SEQ and BUSY never occur with single transfers; hsize is not checked
  // because every register is one whole word
  assign access_go = i_hsel & i_hready & (i_htrans == `ICS_HTRANS_NONSEQ);

  // Every transfer costs one wait state: the access happens in the
  // cycle after the address phase, so a read never sees a stale write
  // Only one access is ever in flight, so no address queue is needed
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_state_q <= ICS_BUS_IDLE;
      addr_q <= '0;
      write_q <= 1'b0;
      hready_q <= 1'b1;
    end else begin
      unique case (bus_state_q)
        ICS_BUS_IDLE: begin
          if (access_go) begin
            bus_state_q <= ICS_BUS_ACCESS;
            addr_q <= i_haddr;
            write_q <= i_hwrite;
            hready_q <= 1'b0;
          end
        end
        ICS_BUS_ACCESS: begin
          bus_state_q <= ICS_BUS_IDLE;
          hready_q <= 1'b1;
        end
      endcase
    end
  end

  // Write strobes, valid in the access cycle while hwdata stands
  // Each strobe lasts exactly one cycle, the single access-state cycle
  assign wr_status = (bus_state_q == ICS_BUS_ACCESS) & write_q
                     & ics_hit(addr_q, `ICS_OFF_STATUS);
  assign wr_enable = (bus_state_q == ICS_BUS_ACCESS) & write_q
                     & ics_hit(addr_q, `ICS_OFF_ENABLE);
  assign wr_cfg = (bus_state_q == ICS_BUS_ACCESS) & write_q
                  & ics_hit(addr_q, `ICS_OFF_IRQ_CFG);
  assign wr_power = (bus_state_q == ICS_BUS_ACCESS) & write_q
                    & ics_hit(addr_q, `ICS_OFF_POWER);
  assign wr_byte_test = (bus_state_q == ICS_BUS_ACCESS) & write_q
                        & ics_hit(addr_q, `ICS_OFF_BYTE_TEST);

  // Read data is captured in the access cycle; unmapped reads give zero
  // Reads have no side effects, so a stray status read loses nothing
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hrdata_q <= '0;
    end else if (bus_state_q == ICS_BUS_ACCESS && !write_q) begin
      hrdata_q <= '0;
      if (ics_hit(addr_q, `ICS_OFF_STATUS)) begin
        hrdata_q <= status_q & `ICS_STS_IMPL_MASK;
      end
      if (ics_hit(addr_q, `ICS_OFF_ENABLE)) begin
        hrdata_q <= enable_q;
      end
      if (ics_hit(addr_q, `ICS_OFF_IRQ_CFG)) begin
        hrdata_q[`ICS_DEAS_MSB:`ICS_DEAS_LSB] <= deas_q;
        hrdata_q[`ICS_DEAS_STS_BIT] <= holdoff_active;
        hrdata_q[`ICS_IRQ_INT_BIT] <= pend_power | pend_other;
      end
      if (ics_hit(addr_q, `ICS_OFF_POWER)) begin
        hrdata_q[`ICS_PWR_SLEEP_BIT] <= low_power_q;
      end
      if (ics_hit(addr_q, `ICS_OFF_BYTE_TEST)) begin
        hrdata_q <= `ICS_BYTE_TEST_VAL;
      end
    end
  end

  // Enable register; reserved positions never store a one
  // Enabling a bit that is already set raises the output a cycle later
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_q <= `ICS_ENA_RESET;
    end else if (wr_enable) begin
      enable_q <= i_hwdata & `ICS_STS_IMPL_MASK;
    end
  end

  // Software event is raised by the enable going from zero to one, so
  // that a clearing write is not immediately undone by a held enable
  assign sw_en_set = wr_enable
                     & ics_rose(enable_q[`ICS_BIT_SW], i_hwdata[`ICS_BIT_SW]);

  // History of sampled sources used for edge and crossing detection, and as the PHY status bit
  // The timer history resets to all-ones, the timer's own reset value,
  // so no false wrap is seen on the first cycle after reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drop_top_q <= 1'b0;
      timer_prev_q <= `ICS_TIMER_ALL_ONES;
      phy_q <= 1'b0;
    end else begin
      drop_top_q <= i_drop_count[31];
      timer_prev_q <= i_timer_count;
      phy_q <= i_phy_event;
    end
  end

  // Gather this cycle's events into one set vector
  always_comb begin
    set_vec = '0;
    // Software and engine halt events
    set_vec[`ICS_BIT_SW] = sw_en_set;
    set_vec[`ICS_BIT_TX_HALT] = i_tx_halt_req & i_tx_halted;
    set_vec[`ICS_BIT_RX_HALT] = i_rx_halted;
    // Counter crossings, judged against last cycle's value
    set_vec[`ICS_BIT_DROP_MID] = ics_rose(drop_top_q,
                                          i_drop_count == `ICS_DROP_MIDPOINT);
    // Completion pulses from the transfer paths, and the timer wrap
    set_vec[`ICS_BIT_TRANSMIT_BUFFER_COMPLETE_FLAG] = i_tx_buf_done_ioc;
    set_vec[`ICS_BIT_RX_DMA] = i_rx_dma_done;
    set_vec[`ICS_BIT_TIMER] = (timer_prev_q == `ICS_TIMER_ZERO)
                              & (i_timer_count == `ICS_TIMER_ALL_ONES);
    // Power event; it also bypasses the hold-off further down
    set_vec[`ICS_BIT_POWER] = i_power_event;
    // Error, overflow and underrun reports
    set_vec[`ICS_BIT_TX_STS_OVF] = i_tx_status_overflow;
    set_vec[`ICS_BIT_RX_OVERSIZE] = i_rx_oversize;
    set_vec[`ICS_BIT_RX_ERR] = i_rx_error;
    set_vec[`ICS_BIT_TX_ERR] = i_tx_error;
    set_vec[`ICS_BIT_TX_UNDERRUN] = i_tx_data_underrun;
    set_vec[`ICS_BIT_TX_OVERRUN] = i_tx_data_write & i_tx_data_full;
    // FIFO levels set the bit every cycle they stand, so a clear while
    // the level still holds is overridden at once
    set_vec[`ICS_BIT_TX_SPACE] = i_tx_space_above;
    set_vec[`ICS_BIT_TX_STS_FULL] = i_tx_status_full;
    set_vec[`ICS_BIT_TX_STS_LVL] = i_tx_status_level;
    set_vec[`ICS_BIT_RX_DROPPED] = i_rx_frame_dropped;
    set_vec[`ICS_BIT_RX_DATA_LVL] = i_rx_data_level;
    set_vec[`ICS_BIT_RX_STS_FULL] = i_rx_status_full;
    set_vec[`ICS_BIT_RX_STS_LVL] = i_rx_status_level;
    // Pin events arrive already qualified by the pin configuration
    set_vec[`ICS_BIT_PIN_LSB +: PIN_W] = i_pin_events;
  end

  // Clear vector: ones written to clearable bits; the PHY bit is excluded
  // Zeros leave bits alone, so one source is cleared without racing others
  assign clr_vec = wr_status ? (i_hwdata & `ICS_STS_CLR_MASK) : '0;

  // Sticky update; the set term is applied after the clear so it wins
  always_comb begin
    status_d = ((status_q & ~clr_vec) | set_vec) & `ICS_STS_IMPL_MASK;
    status_d[`ICS_BIT_PHY] = phy_q;
  end

  // Status register; reserved bits are masked on every update, so no
  // source wired to them can leak into a read
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= `ICS_STS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Pending sources after masking; status itself is never masked
  // Only bit 17 skips the hold-off; the software flag waits like the rest
  assign pend_power = status_q[`ICS_BIT_POWER] & enable_q[`ICS_BIT_POWER];
  assign pend_other = |(status_q & enable_q
                        & ~(`ICS_STS_RESET | (32'h1 << `ICS_BIT_POWER)));

  // Hold-off configuration; writing a zero interval cancels a running one
  // A new interval takes effect at the next load; a running count is kept
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      deas_q <= '0;
    end else if (wr_cfg) begin
      deas_q <= i_hwdata[`ICS_DEAS_MSB:`ICS_DEAS_LSB];
    end
  end

  // Unit tick divider, one pulse per hold-off unit; only runs while
  // an interval is active, so each interval is counted from its start
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_q <= '0;
    end else if (!holdoff_active || holdoff_load) begin
      prescale_q <= '0;
    end else if (unit_tick) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
    end
  end
  // The tick falls on the last cycle of each unit
  assign unit_tick = (prescale_q == `ICS_PRESCALE_W'(`ICS_HOLDOFF_UNIT_CYC - 1));

  // Interval running while the count is nonzero
  assign holdoff_active = (holdoff_cnt_q != 8'h00);

  // A fresh load also restarts the divider, so a restarted interval is never cut short
  assign holdoff_load = (wr_cfg & i_hwdata[`ICS_DEAS_CLR_BIT]) | (irq_q & ~irq_d);

  // Interval starts when the output drops; a clear bit restarts it and
  // a zero interval written by software releases pending requests
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      holdoff_cnt_q <= '0;
    end else if (wr_cfg && i_hwdata[`ICS_DEAS_MSB:`ICS_DEAS_LSB] == 8'h00) begin
      holdoff_cnt_q <= '0;
    end else if (wr_cfg && i_hwdata[`ICS_DEAS_CLR_BIT]) begin
      holdoff_cnt_q <= i_hwdata[`ICS_DEAS_MSB:`ICS_DEAS_LSB];
    end else if (irq_q && !irq_d) begin
      holdoff_cnt_q <= deas_q;
    end else if (holdoff_active && unit_tick) begin
      holdoff_cnt_q <= holdoff_cnt_q - 1'b1;
    end
  end

  // Power event is never held back by the interval
  // Trade-off: the output is a flop, so it trails the status by a cycle
  assign irq_d = pend_power | (pend_other & ~holdoff_active);

  // Interrupt output flop
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Low-power state: entered by software, left only by a byte-test
  // write; a power event only flags status and never wakes the block
  // Status keeps collecting while asleep, so no event is lost
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_power_q <= 1'b0;
    end else if (wr_byte_test) begin
      low_power_q <= 1'b0;
    end else if (wr_power && i_hwdata[`ICS_PWR_SLEEP_BIT]) begin
      low_power_q <= 1'b1;
    end
  end

  // Outputs straight from flops, hresp tied low; only OKAY responses exist
  // No ERROR response: unmapped places read zero and ignore writes
  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hready_q;
  assign o_hresp = 1'b0;
  assign o_irq = irq_q;
  assign o_low_power = low_power_q;

endmodule
`default_nettype wire

// ---- tb/ics_collector_assertions.sv ----
// Concurrent checks on the status collector ports
`include "ics_defs.svh"
`default_nettype none
module ics_collector_assertions #(
  parameter int ADDR_W = 8,
  parameter int PIN_W = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [ADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire ics_pkg::ics_word_t o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_tx_halt_req,
  input wire logic i_tx_halted,
  input wire logic i_rx_halted,
  input wire logic i_rx_error,
  input wire logic i_tx_data_write,
  input wire logic i_tx_data_full,
  input wire logic [PIN_W-1:0] i_pin_events,
  input wire logic o_low_power
);
  import ics_pkg::*;
  logic taken;
  logic wake_wr;
  // Address phase accepted, and the one write that may end low power
  assign taken = i_hsel && i_hready && (i_htrans == `ICS_HTRANS_NONSEQ);
  assign wake_wr = taken && i_hwrite && (i_haddr == `ICS_OFF_BYTE_TEST);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Status read accepted; its data is sampled two edges later
  sequence s_sts_rd;
    taken && !i_hwrite && (i_haddr == `ICS_OFF_STATUS);
  endsequence
  a_bus_okay: assert property (o_hresp == 1'b0) else $error("response not okay");
  a_one_wait: assert property (taken |=> !o_hreadyout ##1 o_hreadyout)
    else $error("wait state count wrong");
  a_tx_halt_latch: assert property (s_sts_rd ##0 (i_tx_halt_req && i_tx_halted) |-> ##2 o_hrdata[25])
    else $error("transmit halt not latched");
  a_rx_halt_latch: assert property (s_sts_rd ##0 i_rx_halted |-> ##2 o_hrdata[24])
    else $error("receive halt not latched");
  a_rx_err_latch: assert property (s_sts_rd ##0 i_rx_error |-> ##2 o_hrdata[14])
    else $error("receive error not latched");
  a_overrun_latch: assert property (s_sts_rd ##0 (i_tx_data_write && i_tx_data_full)
    |-> ##2 o_hrdata[10]) else $error("overrun not latched");
  a_pin_latch: assert property (s_sts_rd |-> ##2
    ((o_hrdata[PIN_W-1:0] & $past(i_pin_events, 2)) == $past(i_pin_events, 2)))
    else $error("pin event not latched");
  a_reserved_zero: assert property (s_sts_rd |-> ##2 ((o_hrdata & ~`ICS_STS_IMPL_MASK) == 32'h0))
    else $error("reserved status bit read nonzero");
  a_wake_byte_test: assert property ($fell(o_low_power) |-> $past(wake_wr, 2))
    else $error("low power left without byte test write");
endmodule
`default_nettype wire

// ---- tb/ics_host_model.sv ----
// Bus master standing in for the host processor
`default_nettype none
module ics_host_model (
  input wire logic i_core_clk,
  input wire logic i_hready,
  input wire ics_pkg::ics_word_t i_hrdata,
  output logic o_hsel,
  output logic [7:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output ics_pkg::ics_word_t o_hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ics_pkg::*;
  // Idle bus at time zero
  initial begin
    o_hsel = 1'b0;
    o_haddr = 8'h00;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
  end
  // One single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input ics_word_t d,
                      output ics_word_t q);
    @(posedge i_core_clk);
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_hwrite <= w;
    o_htrans <= 2'h2;
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    o_hsel <= 1'b0;
    o_htrans <= 2'h0;
    o_hwdata <= d; // A one acknowledges that status bit
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    q = i_hrdata;
    o_hwdata <= ~d; // Stale data must not look valid
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the interrupt status collector
`include "ics_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ics_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic hsel, hwrite, hready, hresp, irq, low_power;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  ics_word_t hwdata, hrdata, q;
  ics_word_t ev = 32'h0;
  ics_word_t drop = 32'h0;
  logic [15:0] timer = 16'hffff;
  int n_mismatch = 0;
  int n_compared = 0;
  always #4 i_core_clk = ~i_core_clk;
  ics_host_model host (.i_core_clk(i_core_clk), .i_hready(hready), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
    .o_hwdata(hwdata));
  // Bits 26 and 12 give half a condition only, to show it is not enough
  ics_collector dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hready),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_tx_halt_req(ev[25] | ev[26]), .i_tx_halted(ev[25]), .i_rx_halted(ev[24]),
    .i_drop_count(drop), .i_tx_buf_done_ioc(ev[21]), .i_rx_dma_done(ev[20]),
    .i_timer_count(timer), .i_phy_event(ev[18]), .i_power_event(ev[17]),
    .i_tx_status_overflow(ev[16]), .i_rx_oversize(ev[15]), .i_rx_error(ev[14]),
    .i_tx_error(ev[13]), .i_tx_data_write(ev[10]), .i_tx_data_full(ev[10] | ev[12]),
    .i_tx_data_underrun(ev[11]), .i_tx_space_above(ev[9]), .i_tx_status_full(ev[8]),
    .i_tx_status_level(ev[7]), .i_rx_frame_dropped(ev[6]), .i_rx_data_level(ev[5]),
    .i_rx_status_full(ev[4]), .i_rx_status_level(ev[3]), .i_pin_events(ev[2:0]),
    .o_irq(irq), .o_low_power(low_power));
  task automatic chk(input ics_word_t got, input ics_word_t exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input ics_word_t d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input ics_word_t e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic put(input ics_word_t m);
    @(posedge i_core_clk);
    ev <= m;
  endtask
  task automatic pulse(input ics_word_t m);
    put(m);
    put(32'h0);
    repeat (3) @(posedge i_core_clk);
  endtask
  // Reset values, fixed and unmapped places, read-only and reserved bits
  task automatic t_reset;
    rd(`ICS_OFF_STATUS, `ICS_STS_RESET);
    rd(`ICS_OFF_ENABLE, `ICS_ENA_RESET);
    rd(`ICS_OFF_BYTE_TEST, `ICS_BYTE_TEST_VAL);
    rd(8'h70, 32'h0);
    wr(`ICS_OFF_STATUS, 32'hffff_ffff);
    rd(`ICS_OFF_STATUS, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Each source but the software, drop, timer and PHY bits latches, survives a zero write, and clears on a one
  task automatic t_sources;
    int b[23] = '{25, 26, 24, 21, 20, 17, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
    ics_word_t m, e;
    foreach (b[i]) begin
      m = 32'h1 << b[i];
      e = m & `ICS_STS_CLR_MASK;
      put(m);
      rd(`ICS_OFF_STATUS, e);
      put(32'h0);
      wr(`ICS_OFF_STATUS, ~m);
      rd(`ICS_OFF_STATUS, e);
      wr(`ICS_OFF_STATUS, m);
      rd(`ICS_OFF_STATUS, 32'h0);
    end
  endtask
  // Level source held across its clearing write keeps the bit
  task automatic t_phy_hold;
    put(32'h0004_0200);
    wr(`ICS_OFF_STATUS, 32'h0004_0200);
    rd(`ICS_OFF_STATUS, 32'h0004_0200);
    pulse(32'h0);
    wr(`ICS_OFF_STATUS, 32'h0000_0200);
    rd(`ICS_OFF_STATUS, 32'h0);
  endtask
  // Drop counter midpoint and timer wrap
  task automatic t_counters;
    @(posedge i_core_clk);
    drop <= 32'h7fff_ffff;
    @(posedge i_core_clk);
    drop <= `ICS_DROP_MIDPOINT;
    @(posedge i_core_clk);
    timer <= `ICS_TIMER_ZERO;
    @(posedge i_core_clk);
    timer <= `ICS_TIMER_ALL_ONES;
    rd(`ICS_OFF_STATUS, 32'h0088_0000);
    wr(`ICS_OFF_STATUS, 32'h0088_0000);
    rd(`ICS_OFF_STATUS, 32'h0);
  endtask
  // Software flag follows a rising enable bit
  task automatic t_sw;
    wr(`ICS_OFF_ENABLE, 32'h8000_0000);
    rd(`ICS_OFF_STATUS, 32'h8000_0000);
    wr(`ICS_OFF_STATUS, 32'h8000_0000);
    rd(`ICS_OFF_STATUS, 32'h0);
    wr(`ICS_OFF_ENABLE, 32'h0);
  endtask
  // Masking, then hold-off that blocks all but the power source
  task automatic t_irq;
    wr(`ICS_OFF_ENABLE, 32'h0002_0040);
    pulse(32'h20);
    chk({31'h0, irq}, 32'h0);
    pulse(32'h40);
    chk({31'h0, irq}, 32'h1);
    wr(`ICS_OFF_IRQ_CFG, 32'h0100_0000);
    wr(`ICS_OFF_STATUS, 32'h60);
    pulse(32'h40);
    chk({31'h0, irq}, 32'h0);
    rd(`ICS_OFF_IRQ_CFG, 32'h0100_3000);
    pulse(32'h0002_0000);
    chk({31'h0, irq}, 32'h1);
    wr(`ICS_OFF_STATUS, 32'h0002_0000);
    repeat (2) @(posedge i_core_clk);
    chk({31'h0, irq}, 32'h0);
    repeat (1300) @(posedge i_core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`ICS_OFF_STATUS, 32'h0002_0040);
    wr(`ICS_OFF_IRQ_CFG, 32'h0);
    rd(`ICS_OFF_IRQ_CFG, 32'h0);
    wr(`ICS_OFF_ENABLE, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  // Power event latches but never wakes; any byte test write does
  task automatic t_power;
    wr(`ICS_OFF_POWER, 32'h1);
    rd(`ICS_OFF_POWER, 32'h1);
    pulse(32'h0002_0000);
    chk({31'h0, low_power}, 32'h1);
    rd(`ICS_OFF_STATUS, 32'h0002_0000);
    wr(`ICS_OFF_STATUS, 32'h0002_0000);
    rd(`ICS_OFF_STATUS, 32'h0);
    wr(`ICS_OFF_BYTE_TEST, 32'h0);
    chk({31'h0, low_power}, 32'h0);
  endtask
  task automatic summarize;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_sources;
    t_phy_hold;
    t_counters;
    t_sw;
    t_irq;
    t_power;
    summarize;
  end
  // Watchdog: the run needs a few thousand cycles at most
  initial begin
    #160000;
    n_mismatch++;
    summarize;
  end
endmodule
bind ics_collector ics_collector_assertions #(.ADDR_W(ADDR_W), .PIN_W(PIN_W)) u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_tx_halt_req(i_tx_halt_req),
  .i_tx_halted(i_tx_halted), .i_rx_halted(i_rx_halted), .i_rx_error(i_rx_error),
  .i_tx_data_write(i_tx_data_write), .i_tx_data_full(i_tx_data_full),
  .i_pin_events(i_pin_events), .o_low_power(o_low_power));
`default_nettype wire
